/* File: verilog/i2c_timing_defs.svh */
`ifndef I2C_TIMING_DEFS_SVH
`define I2C_TIMING_DEFS_SVH

// register offsets
`define ADDR_ACK_WD_CTRL   8'h0a
`define ADDR_CLK_HIGH      8'h0b
`define ADDR_CLK_LOW       8'h0c
`define ADDR_WD_STATUS     8'h0f

// reset values
`define ACK_WD_CTRL_RST    8'h10
`define CLK_HIGH_RST       8'h7f
`define CLK_LOW_RST        8'h7f

// field positions in remote_ack_and_watchdog_ctrl
`define FLD_SETUP_HI       7
`define FLD_SETUP_LO       4
`define FLD_DELAY_HI       3
`define FLD_DELAY_LO       2
`define BIT_WD_FAST        1
`define BIT_WD_OFF         0

// status register fields
`define BIT_ST_FREE        0
`define BIT_ST_RECOVER     1

// timing, in picoseconds unless named otherwise
`define SYS_CLK_PS         50000
`define SYS_CLK_NS         50
`define OSC_PERIOD_PS      38096
`define OSC_EXTRA_UNITS    5
`define ACK_SETUP_BASE_PS  80000
`define ACK_SETUP_STEP_PS  640000
`define SDA_DELAY_BASE_PS  240000
`define SDA_DELAY_STEP_PS  40000
`define WD_SLOW_NS         1000000000
`define WD_FAST_NS         50000
`define WD_SLOW_CYC        (`WD_SLOW_NS / `SYS_CLK_NS)
`define WD_FAST_CYC        (`WD_FAST_NS / `SYS_CLK_NS)
`define RECOVERY_PULSES    9

`endif

/* File: verilog/i2c_timing_pkg.sv */
package i2c_timing_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOW  = 3'b001,
      ST_RISE = 3'b010,
      ST_HIGH = 3'b011,
      ST_HOLD = 3'b100
   } phase_t;

   typedef struct packed {
      logic        running;
      logic [25:0] acc;
      logic        done;
   } timer_state_t;

   typedef struct packed {
      logic [1:0]  scl_sync;
      logic [1:0]  sda_sync;
      logic        scl_q;
      logic        sda_q;
      logic [7:0]  ctl;
      logic [7:0]  hi_cnt;
      logic [7:0]  lo_cnt;
      logic [7:0]  rdata;
      phase_t      st;
      logic [24:0] wd_cnt;
      logic        bus_free;
      logic        recovering;
      logic [3:0]  pulses;
      logic        scl_oe;
      logic        sda_oe;
      logic        sda_pend;
      logic        sda_wait;
      logic        armed;
      logic        ack_x;
      logic        t_start;
      logic [25:0] t_target;
      logic        d_start;
      logic [25:0] d_target;
   } ctrl_state_t;

endpackage

/* File: verilog/osc_phase_timer.sv */
`timescale 1ns/10ps
`include "i2c_timing_defs.svh"

// counts elapsed picoseconds in whole system clocks, so a least time always rounds up
module osc_phase_timer (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // request
   input  wire logic        start,
   input  wire logic [25:0] target,
   // answer, level until the next start
   output      logic        done
);

   i2c_timing_pkg::timer_state_t s;
   i2c_timing_pkg::timer_state_t next_s;

   always_comb begin
      logic [25:0] sum;
      sum    = s.acc + 26'(`SYS_CLK_PS);
      next_s = s;
      if (start) begin
         next_s.running = 1'b1;
         next_s.acc     = 26'h0;
         next_s.done    = 1'b0;
      end else if (s.running) begin
         next_s.acc = sum;
         if (sum >= target) begin
            next_s.done    = 1'b1;
            next_s.running = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;

endmodule

/* File: verilog/i2c_timing_watchdog.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "i2c_timing_defs.svh"

// What this block does
// - remote ack cycles add 640 ns data setup per count of the setup field.
// - setup field zero still gives 80 ns setup before the clock rises.
// - the ack setup extension applies only during remote control-channel accesses.
// - each output delay count adds 40 ns after the clock falls.
// - data output follows the falling clock by 240, 280, 320 or 360 ns.
// - watchdog expires after about 1 s, or 50 us when fast is set.
// - watchdog disable bit 0 stops free detection and the start of hung bus recovery; a recovery already running continues.
// - data high and idle until expiry means the bus is free.
// - data low and idle until expiry triggers nine recovery clock pulses.
// - controller clock high lasts at least (high count + 5) oscillator periods.
// - controller clock low lasts at least (low count + 5) oscillator periods.
// - clock phases are counted in 38.1 ns oscillator periods.
// - as remote target, the low count sets data setup before releasing stretch.
// - high and low counts reset to 0x7f.
module i2c_timing_watchdog #(
   parameter int unsigned WD_SLOW_CYC = `WD_SLOW_CYC
) (
   // clock and reset
   input  wire logic       SYS_CLK,
   input  wire logic       NRST,
   // register port
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   output      logic [7:0] REG_RDATA,
   // transfer engine side
   input  wire logic       CTL_CLK_EN,
   input  wire logic       TX_SDA,
   input  wire logic       TGT_STRETCH,
   input  wire logic       REMOTE_ACTIVE,
   input  wire logic       ACK_PHASE,
   // status
   output      logic       BUS_FREE,
   output      logic       BUS_RECOVERING,
   // bus pins, open drain
   input  wire logic       SCL_I,
   output      logic       SCL_O,
   output      logic       SCL_OE,
   input  wire logic       SDA_I,
   output      logic       SDA_O,
   output      logic       SDA_OE
);

   logic [1:0]                  rst_sync;
   logic                        rst_n;
   i2c_timing_pkg::ctrl_state_t s;
   i2c_timing_pkg::ctrl_state_t next_s;
   logic                        t_done;
   logic                        d_done;
   logic [24:0]                 wd_limit;
   logic                        activity;

   // oscillator-period count converted to picoseconds
   function automatic logic [25:0] osc_ps(input logic [7:0] n);
      return 26'(({18'h0, n} + 26'(`OSC_EXTRA_UNITS)) * 26'(`OSC_PERIOD_PS));
   endfunction

   function automatic logic [25:0] ack_setup_ps(input logic [3:0] f);
      return 26'(`ACK_SETUP_BASE_PS) + 26'({22'h0, f} * 26'(`ACK_SETUP_STEP_PS));
   endfunction

   function automatic logic [15:0] ceil_cyc(input logic [25:0] ps);
      return 16'((ps + 26'(`SYS_CLK_PS - 1)) / 26'(`SYS_CLK_PS));
   endfunction

   // reset released through two flip-flops
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   osc_phase_timer phase_timer (
      .clk    (SYS_CLK),
      .rst_n  (rst_n),
      .start  (s.t_start),
      .target (s.t_target),
      .done   (t_done)
   );

   osc_phase_timer sda_timer (
      .clk    (SYS_CLK),
      .rst_n  (rst_n),
      .start  (s.d_start),
      .target (s.d_target),
      .done   (d_done)
   );

   assign wd_limit = s.ctl[`BIT_WD_FAST] ? 25'(`WD_FAST_CYC) : 25'(WD_SLOW_CYC);
   assign activity = (s.scl_sync[1] != s.scl_q) || (s.sda_sync[1] != s.sda_q);

   always_comb begin
      logic scl;
      logic sda;
      logic fell;
      scl    = s.scl_sync[1];
      sda    = s.sda_sync[1];
      fell   = s.scl_q && !scl;
      next_s = s;
      next_s.t_start  = 1'b0;
      next_s.d_start  = 1'b0;
      // only the second stage of each synchroniser is read
      next_s.scl_sync = {s.scl_sync[0], SCL_I};
      next_s.sda_sync = {s.sda_sync[0], SDA_I};
      next_s.scl_q    = scl;
      next_s.sda_q    = sda;

      if (REG_WR) begin
         case (REG_ADDR)
            `ADDR_ACK_WD_CTRL: next_s.ctl    = REG_WDATA;
            `ADDR_CLK_HIGH:    next_s.hi_cnt = REG_WDATA;
            `ADDR_CLK_LOW:     next_s.lo_cnt = REG_WDATA;
            default:           next_s.ctl    = s.ctl;
         endcase
      end
      if (REG_RD) begin
         case (REG_ADDR)
            `ADDR_ACK_WD_CTRL: next_s.rdata = s.ctl;
            `ADDR_CLK_HIGH:    next_s.rdata = s.hi_cnt;
            `ADDR_CLK_LOW:     next_s.rdata = s.lo_cnt;
            `ADDR_WD_STATUS:   next_s.rdata = {6'h0, s.recovering, s.bus_free};
            default:           next_s.rdata = 8'h00;
         endcase
      end

      // bus watchdog, counted in system clocks derived from the same time base
      if (s.ctl[`BIT_WD_OFF]) begin
         next_s.wd_cnt   = 25'h0;
         next_s.bus_free = 1'b0;
      end else if (activity) begin
         next_s.wd_cnt   = 25'h0;
         next_s.bus_free = 1'b0;
      end else if (s.wd_cnt < wd_limit) begin
         next_s.wd_cnt = s.wd_cnt + 25'h1;
         if (s.wd_cnt + 25'h1 == wd_limit) begin
            if (sda) begin
               next_s.bus_free = 1'b1;
            end else if (!s.recovering) begin
               next_s.recovering = 1'b1;
               next_s.pulses     = 4'h0;
            end
         end
      end

      // data output follows the falling clock by the programmed delay
      if (fell && !s.recovering) begin
         next_s.d_start  = 1'b1;
         next_s.d_target = 26'(`SDA_DELAY_BASE_PS) +
                           26'({24'h0, s.ctl[`FLD_DELAY_HI:`FLD_DELAY_LO]} * 26'(`SDA_DELAY_STEP_PS));
         next_s.sda_pend = TX_SDA;
         next_s.sda_wait = 1'b1;
      end else if (s.sda_wait && !s.d_start && d_done) begin
         next_s.sda_oe   = !s.sda_pend;
         next_s.sda_wait = 1'b0;
      end
      // recovery keeps data released so a stuck target can finish its byte
      if (s.recovering) begin
         next_s.sda_oe   = 1'b0;
         next_s.sda_wait = 1'b0;
      end

      case (s.st)
         i2c_timing_pkg::ST_IDLE: begin
            next_s.scl_oe = 1'b0;
            if (s.recovering || CTL_CLK_EN) begin
               next_s.st       = i2c_timing_pkg::ST_LOW;
               next_s.scl_oe   = 1'b1;
               next_s.t_start  = 1'b1;
               next_s.t_target = osc_ps(s.lo_cnt);
            end else if (fell && TGT_STRETCH) begin
               next_s.st     = i2c_timing_pkg::ST_HOLD;
               next_s.scl_oe = 1'b1;
               next_s.armed  = 1'b0;
               next_s.ack_x  = REMOTE_ACTIVE && ACK_PHASE;
            end
         end
         i2c_timing_pkg::ST_LOW: begin
            if (!s.t_start && t_done) begin
               next_s.scl_oe = 1'b0;
               next_s.st     = i2c_timing_pkg::ST_RISE;
            end
         end
         i2c_timing_pkg::ST_RISE: begin
            // high time starts only once the line is seen high, so a stretching target is honoured
            if (scl) begin
               next_s.st       = i2c_timing_pkg::ST_HIGH;
               next_s.t_start  = 1'b1;
               next_s.t_target = osc_ps(s.hi_cnt);
            end
         end
         i2c_timing_pkg::ST_HIGH: begin
            if (!s.t_start && t_done) begin
               if (s.recovering && s.pulses == 4'(`RECOVERY_PULSES - 1)) begin
                  next_s.recovering = 1'b0;
                  next_s.st         = i2c_timing_pkg::ST_IDLE;
               end else if (s.recovering || CTL_CLK_EN) begin
                  if (s.recovering) begin
                     next_s.pulses = s.pulses + 4'h1;
                  end
                  next_s.st       = i2c_timing_pkg::ST_LOW;
                  next_s.scl_oe   = 1'b1;
                  next_s.t_start  = 1'b1;
                  next_s.t_target = osc_ps(s.lo_cnt);
               end else begin
                  next_s.st = i2c_timing_pkg::ST_IDLE;
               end
            end
         end
         i2c_timing_pkg::ST_HOLD: begin
            // setup is measured from the data change, not from the clock edge
            if (!s.armed && !s.sda_wait) begin
               next_s.armed    = 1'b1;
               next_s.t_start  = 1'b1;
               next_s.t_target = osc_ps(s.lo_cnt) +
                                 (s.ack_x ? ack_setup_ps(s.ctl[`FLD_SETUP_HI:`FLD_SETUP_LO]) : 26'h0);
            end else if (s.armed && !s.t_start && t_done) begin
               next_s.scl_oe = 1'b0;
               next_s.st     = i2c_timing_pkg::ST_IDLE;
            end
         end
         default: begin
            next_s.st     = i2c_timing_pkg::ST_IDLE;
            next_s.scl_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s          <= '0;
         s.scl_sync <= 2'h3;
         s.sda_sync <= 2'h3;
         s.scl_q    <= 1'b1;
         s.sda_q    <= 1'b1;
         s.ctl      <= `ACK_WD_CTRL_RST;
         s.hi_cnt   <= `CLK_HIGH_RST;
         s.lo_cnt   <= `CLK_LOW_RST;
      end else begin
         s <= next_s;
      end
   end

   assign REG_RDATA      = s.rdata;
   assign BUS_FREE       = s.bus_free;
   assign BUS_RECOVERING = s.recovering;
   assign SCL_OE         = s.scl_oe;
   assign SDA_OE         = s.sda_oe;
   // open drain: the pins only ever pull low
   assign SCL_O          = 1'b0;
   assign SDA_O          = 1'b0;

   // helper counters for the checks below
   logic [15:0] tcnt;
   logic [15:0] dcnt;
   logic [3:0]  rcnt;
   logic        oe_q;

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         tcnt <= 16'h0;
         dcnt <= 16'h0;
         rcnt <= 4'h0;
         oe_q <= 1'b0;
      end else begin
         tcnt <= s.t_start ? 16'h0 : tcnt + 16'h1;
         dcnt <= s.d_start ? 16'h0 : dcnt + 16'h1;
         oe_q <= s.scl_oe;
         if (!s.recovering) begin
            rcnt <= 4'h0;
         end else if (s.scl_oe && !oe_q) begin
            rcnt <= rcnt + 4'h1;
         end
      end
   end

   ack_setup_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (s.st == i2c_timing_pkg::ST_HOLD && s.armed && $rose(t_done)) |->
      tcnt == ceil_cyc(osc_ps(s.lo_cnt) + (s.ack_x ? ack_setup_ps(s.ctl[7:4]) : 26'h0)))
      else $error("stretch release setup time wrong");

   sda_delay_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      $rose(d_done) |-> dcnt == ceil_cyc(26'(`SDA_DELAY_BASE_PS) + 26'({24'h0, s.ctl[3:2]} * 26'(`SDA_DELAY_STEP_PS))))
      else $error("data output delay wrong");

   clk_high_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (s.st == i2c_timing_pkg::ST_HIGH && $rose(t_done)) |-> tcnt == ceil_cyc(osc_ps(s.hi_cnt)))
      else $error("clock high time wrong");

   clk_low_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (s.st == i2c_timing_pkg::ST_LOW && $rose(t_done)) |-> tcnt == ceil_cyc(osc_ps(s.lo_cnt)) && SCL_OE)
      else $error("clock low time wrong");

   wd_bound_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      $rose(s.bus_free) |-> $past(s.wd_cnt) + 25'h1 == wd_limit)
      else $error("watchdog expiry count wrong");

   wd_off_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      (s.ctl[0] && !s.recovering) |=> !s.recovering && !s.bus_free)
      else $error("disabled watchdog still acted");

   bus_free_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      $rose(s.bus_free) |-> s.sda_q && $past(s.sda_sync[1]))
      else $error("bus free with data low");

   nine_clk_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      $fell(s.recovering) |-> rcnt == 4'(`RECOVERY_PULSES) && !SDA_OE)
      else $error("recovery pulse count wrong");

   reset_cnt_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      $rose(rst_n) |-> s.hi_cnt == 8'h7f && s.lo_cnt == 8'h7f)
      else $error("phase counts not at reset value");

   wd_restart_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      activity |=> s.wd_cnt == 25'h0 && !s.bus_free)
      else $error("watchdog not restarted by activity");

endmodule

/* File: tb/bus_target_model.sv */
`timescale 1ns/10ps

// local bus targets: a hung one pins data low, a busy one holds the clock low;
// once released, the pull-ups decide the level, never the last driven value
module bus_target_model (
   // clock
   input  wire logic clk,
   // commands from the bench
   input  wire logic hang_sda,
   input  wire logic hold_scl,
   // open-drain pulls, high = pull low
   output      logic sda_pull,
   output      logic scl_pull
);
   // pulls change just after an edge, as a clocked target would; one process owns both
   always @(posedge clk) begin
      sda_pull <= hang_sda;
      scl_pull <= hold_scl;
   end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`include "i2c_timing_defs.svh"

module testbench;
   logic       SYS_CLK = 1'b0;
   logic       NRST = 1'b0;
   logic [7:0] REG_ADDR = 8'h00;
   logic [7:0] REG_WDATA = 8'h00;
   logic       REG_WR = 1'b0;
   logic       REG_RD = 1'b0;
   logic [7:0] REG_RDATA;
   logic       CTL_CLK_EN = 1'b0;
   logic       TX_SDA = 1'b1;
   logic       TGT_STRETCH = 1'b0;
   logic       REMOTE_ACTIVE = 1'b0;
   logic       ACK_PHASE = 1'b0;
   logic       BUS_FREE, BUS_RECOVERING;
   logic       SCL_O, SCL_OE, SDA_O, SDA_OE;
   logic       hang_sda = 1'b0;
   logic       hold_scl = 1'b0;
   logic       sda_pull, scl_pull;
   wire        scl = !(SCL_OE && !SCL_O) && !scl_pull;
   wire        sda = !(SDA_OE && !SDA_O) && !sda_pull;
   logic [7:0] exp_q[$];
   logic [7:0] v;
   logic       rd_pend = 1'b0;
   logic       prev;
   int         bad_count = 0;
   int         checked = 0;
   int         i, k, n, m, base, r, lo_n, hi_n, lo_v, hi_v, falls;

   always #25 SYS_CLK = ~SYS_CLK;

   // small slow watchdog count keeps the run short
   i2c_timing_watchdog #(.WD_SLOW_CYC(2000)) uut (
      .SYS_CLK(SYS_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CTL_CLK_EN(CTL_CLK_EN),
      .TX_SDA(TX_SDA), .TGT_STRETCH(TGT_STRETCH), .REMOTE_ACTIVE(REMOTE_ACTIVE),
      .ACK_PHASE(ACK_PHASE), .BUS_FREE(BUS_FREE), .BUS_RECOVERING(BUS_RECOVERING),
      .SCL_I(scl), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE(SDA_OE));

   bus_target_model partner (
      .clk(SYS_CLK), .hang_sda(hang_sda), .hold_scl(hold_scl),
      .sda_pull(sda_pull), .scl_pull(scl_pull));

   task check(input string name, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task test_done;
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function int ceil_div(input int a, input int b);
      return (a + b - 1) / b;
   endfunction

   task cyc(input int c);
      repeat (c) @(posedge SYS_CLK);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      exp_q.push_back(e);
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
   endtask

   // read data appear in the cycle after the strobe and hold until the next read; look mid-cycle, clear of the launching edge
   always @(posedge SYS_CLK) begin
      rd_pend <= REG_RD;
   end

   always @(negedge SYS_CLK) begin
      if (rd_pend)
         check("read data", REG_RDATA, exp_q.pop_front());
   end

   task until_scl(input logic lv);
      for (int j = 0; j < 4000 && scl !== lv; j++) cyc(1);
   endtask

   // one data-line blip counts as bus activity
   task kick;
      hang_sda <= 1'b1;
      cyc(3);
      hang_sda <= 1'b0;
      cyc(6);
   endtask

   task meas(output int lo, output int hi);
      until_scl(1'b1);
      until_scl(1'b0);
      lo = 0;
      hi = 0;
      while (scl === 1'b0 && lo < 4000) begin
         cyc(1);
         lo++;
      end
      while (scl === 1'b1 && hi < 4000) begin
         cyc(1);
         hi++;
      end
   endtask

   // outside controller pulls the clock low; the block then stretches it
   task stretch(input logic ra, input logic ap, output int len);
      REMOTE_ACTIVE <= ra;
      ACK_PHASE <= ap;
      TGT_STRETCH <= 1'b1;
      hold_scl <= 1'b1;
      for (int j = 0; j < 50 && SCL_OE !== 1'b1; j++) cyc(1);
      hold_scl <= 1'b0;
      len = 0;
      while (SCL_OE === 1'b1 && len < 400) begin
         cyc(1);
         len++;
      end
      TGT_STRETCH <= 1'b0;
      cyc(20);
   endtask

   initial begin
      #4000000;
      bad_count++;
      test_done;
   end

   initial begin
      void'($urandom(96));
      cyc(5);
      NRST <= 1'b1;
      cyc(4);
      rd(8'h0a, `ACK_WD_CTRL_RST);
      rd(8'h0b, `CLK_HIGH_RST);
      rd(8'h0c, `CLK_LOW_RST);
      wr(8'h20, 8'h5a);
      rd(8'h20, 8'h00);
      for (k = 0; k < 3; k++) begin
         v = 8'($urandom);
         wr(8'h0a + 8'(k), v);
         rd(8'h0a + 8'(k), v);
      end
      // fast watchdog: idle high lines mean a free bus
      wr(8'h0a, 8'h02);
      kick;
      cyc(950);
      check("free too early", BUS_FREE, 1'b0);
      for (i = 0; i < 100 && BUS_FREE !== 1'b1; i++) cyc(1);
      check("bus free", BUS_FREE, 1'b1);
      rd(8'h0f, 8'h01);
      kick;
      check("free after activity", BUS_FREE, 1'b0);
      // disabled watchdog neither frees nor recovers
      wr(8'h0a, 8'h03);
      hang_sda <= 1'b1;
      cyc(1200);
      check("free when off", BUS_FREE, 1'b0);
      check("recover when off", BUS_RECOVERING, 1'b0);
      wr(8'h0a, 8'h02);
      hang_sda <= 1'b0;
      // a zero bit is offered at each recovery fall; recovery ignores it and keeps data released for the quiet check
      TX_SDA <= 1'b0;
      cyc(4);
      hang_sda <= 1'b1;
      for (i = 0; i < 1200 && BUS_RECOVERING !== 1'b1; i++) cyc(1);
      check("recovery start", BUS_RECOVERING, 1'b1);
      rd(8'h0f, 8'h02);
      falls = 0;
      n = 0;
      prev = 1'b1;
      // random phase counts from the register test can make each pulse about 400 cycles long
      for (i = 0; i < 4000 && BUS_RECOVERING === 1'b1; i++) begin
         cyc(1);
         if (prev === 1'b1 && scl === 1'b0) falls++;
         if (SDA_OE !== 1'b0) n++;
         prev = scl;
      end
      hang_sda <= 1'b0;
      TX_SDA <= 1'b1;
      check("recovery pulses", 16'(falls), 16'(`RECOVERY_PULSES));
      check("data quiet in recovery", 16'(n), 16'h0000);
      // slow watchdog, shortened by the parameter
      wr(8'h0a, 8'h00);
      kick;
      cyc(1900);
      check("slow free early", BUS_FREE, 1'b0);
      for (i = 0; i < 300 && BUS_FREE !== 1'b1; i++) cyc(1);
      check("slow free", BUS_FREE, 1'b1);
      // controller clock phases, random counts
      wr(8'h0a, 8'h01);
      for (k = 0; k < 2; k++) begin
         hi_v = $urandom % 64;
         lo_v = $urandom % 64;
         wr(8'h0b, 8'(hi_v));
         wr(8'h0c, 8'(lo_v));
         CTL_CLK_EN <= 1'b1;
         meas(lo_n, hi_n);
         meas(lo_n, hi_n);
         CTL_CLK_EN <= 1'b0;
         m = ceil_div((lo_v + `OSC_EXTRA_UNITS) * `OSC_PERIOD_PS, `SYS_CLK_PS);
         check("low phase", lo_n >= m && lo_n <= m + 5, 1'b1);
         m = ceil_div((hi_v + `OSC_EXTRA_UNITS) * `OSC_PERIOD_PS, `SYS_CLK_PS);
         check("high phase", hi_n >= m && hi_n <= m + 7, 1'b1);
         cyc(300);
      end
      // data delay after the falling clock, every delay code
      wr(8'h0c, 8'h20);
      CTL_CLK_EN <= 1'b1;
      for (k = 0; k < 4; k++) begin
         wr(8'h0a, {4'h0, 2'(k), 2'b01});
         until_scl(1'b1);
         TX_SDA <= ~TX_SDA;
         cyc(1);
         prev = SDA_OE;
         until_scl(1'b0);
         n = 0;
         while (SDA_OE === prev && n < 100) begin
            cyc(1);
            n++;
         end
         check("data line level", sda, !SDA_OE);
         m = ceil_div(240 + 40 * k, `SYS_CLK_NS);
         check("data delay", n >= m + 1 && n <= m + 6, 1'b1);
      end
      CTL_CLK_EN <= 1'b0;
      TX_SDA <= 1'b1;
      cyc(300);
      // target stretch: extension only on remote acknowledge bits
      wr(8'h0a, 8'h01);
      stretch(1'b0, 1'b0, base);
      stretch(1'b1, 1'b0, r);
      check("no ext remote data", (r - base) inside {[-1:1]}, 1'b1);
      stretch(1'b0, 1'b1, r);
      check("no ext local ack", (r - base) inside {[-1:1]}, 1'b1);
      stretch(1'b1, 1'b1, r);
      check("ack setup zero", (r - base) inside {[1:3]}, 1'b1);
      wr(8'h0a, 8'h31);
      stretch(1'b1, 1'b1, r);
      check("ack setup three", (r - base) inside {[39:41]}, 1'b1);
      wr(8'h0a, 8'h01);
      wr(8'h0c, 8'h40);
      stretch(1'b0, 1'b0, r);
      check("target setup low", (r - base) inside {[23:26]}, 1'b1);
      cyc(5);
      test_done;
   end
endmodule
